/* core/scr_pkg.sv */
// Package for the shared configuration and soft reset register bank
// How it works
// - Address field bits 7:1 of 0x00 always read the address in use.
// - With override set, address field is writable and used on the bus.
// - Override bit resets to 0; 0 strapped, 1 register-held address.
// - Bit 2 of 0x01 starts a ROM reload and clears itself.
// - Init-done status bit 6 sets once ROM loading has completed.
// - Bit 1 of 0x01 resets everything including registers, self-clearing.
// - Bit 0 of 0x01 resets logic but keeps registers, self-clearing.
// - Bit 5 of 0x02 enables local bus controller, reset value 0.
// - Bit 4 clear: output port high impedance when no assigned port locked.
// - Bit 4 set (default): transmitter runs under port control, LP-11 unlocked when sleep select and output enable are both 1.
// - Sleep select 1 and output enable 0 force outputs high impedance.
// - Sleep select 0 with lock low and bit 4 set forces outputs to HS-0.
// - Bit 1 of 0x02 enables receive parity checking, default enabled.
// - Bit 0 of 0x02 forces o_refclk_present high; status bit 4 still reads the detector; default 0.
package scr_pkg;
   localparam logic [7:0] REG_BUS_ADDRESS_SELECT   = 8'h00;
   localparam logic [7:0] REG_SOFT_RESET_CONTROL   = 8'h01;
   localparam logic [7:0] REG_GENERAL_CONFIGURATION = 8'h02;
   localparam logic [7:0] REG_DEVICE_STATUS        = 8'h04;
   // Field positions
   localparam int BIT_OVERRIDE   = 0;
   localparam int BIT_RELOAD     = 2;
   localparam int BIT_FULL_RST   = 1;
   localparam int BIT_LOGIC_RST  = 0;
   localparam int BIT_CTRL_EN    = 5;
   localparam int BIT_OUT_MODE   = 4;
   localparam int BIT_OUT_EN     = 3;
   localparam int BIT_SLEEP_SEL  = 2;
   localparam int BIT_PARITY_EN  = 1;
   localparam int BIT_REFCLK_FRC = 0;
   localparam int BIT_INIT_DONE  = 6;
   localparam int BIT_CKSUM_OK   = 7;
   localparam int BIT_REFCLK_OK  = 4;
   // Reset values and writable masks
   localparam logic [7:0] GENCFG_RESET = 8'h1E;
   localparam logic [7:0] GENCFG_MASK  = 8'h3F;
   // Length of the internal reset pulse the soft resets launch
   localparam logic [3:0] SOFT_RST_CYCLES = 4'h4;

   // Output state of the CSI-2 lanes
   typedef enum logic [1:0] {SCR_OUT_NORMAL, SCR_OUT_LP11, SCR_OUT_HS0, SCR_OUT_HIZ} scr_out_type;

   // Configuration bundle handed to the rest of the chip
   typedef struct packed {
      logic ctrl_en;
      logic out_mode;
      logic out_en;
      logic sleep_sel;
      logic parity_en;
      logic refclk_force;
   } scr_cfg_type;

   // Register bus request from the serial slave
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scr_req_type;
endpackage

/* core/scr_loader.sv */
// ROM auto-load sequencer: walks the ROM and reports completion
`timescale 1ns/1ps
`default_nettype none
module scr_loader #(
   parameter int ROM_WORDS = 16
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // Control
   input  wire logic i_start,
   input  wire logic i_rom_ok,
   // Status
   output logic      o_busy,
   output logic      o_done,
   output logic      o_cksum_ok
);
   import scr_pkg::*;

   // The index must count through at least two words to tell start from end
   if (ROM_WORDS < 2)
   begin : g_rom_words_check
      $error("ROM_WORDS too small");
   end

   typedef enum logic [0:0] {LD_IDLE, LD_RUN} scr_ld_state_type;
   typedef struct packed {
      scr_ld_state_type          state;
      logic [$clog2(ROM_WORDS)-1:0] idx;
      logic                      done;
      logic                      cksum;
   } scr_ld_type;

   scr_ld_type r;
   scr_ld_type next_r;

   // Load walk; a start during a load restarts it from word zero
   always_comb
   begin
      next_r = r;
      unique case (r.state)
         LD_IDLE:
         begin
            if (i_start)
            begin
               next_r.state = LD_RUN;
               next_r.idx   = '0;
               next_r.done  = 1'b0;
            end
         end
         LD_RUN:
         begin
            if (i_start)
               next_r.idx = '0;
            else if (r.idx == ($clog2(ROM_WORDS))'(ROM_WORDS - 1))
            begin
               next_r.state = LD_IDLE;
               next_r.done  = 1'b1;
               next_r.cksum = i_rom_ok;
            end
            else
               next_r.idx = r.idx + 1'b1;
         end
      endcase
   end

   // Reset starts a power-up load
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         r.state <= LD_RUN;
         r.idx   <= '0;
         r.done  <= 1'b0;
         r.cksum <= 1'b0;
      end
      else
         r <= next_r;
   end

   assign o_busy     = (r.state == LD_RUN);
   assign o_done     = r.done;
   assign o_cksum_ok = r.cksum;
endmodule // scr_loader
`default_nettype wire

/* core/scr_regs.sv */
// Shared configuration and soft reset register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs #(
   parameter int ROM_WORDS = 16
) (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_sys_rst,
   // Register access from the serial slave
   input  wire scr_pkg::scr_req_type i_req,
   output logic [7:0]                o_rdata,
   // Straps and device status inputs
   input  wire logic [6:0]           i_strap_addr,
   input  wire logic                 i_rom_ok,
   input  wire logic                 i_refclk_detect,
   input  wire logic                 i_any_lock,
   // Outputs to the device
   output logic [6:0]                o_bus_address,
   output scr_pkg::scr_cfg_type      o_cfg,
   output logic                      o_refclk_present,
   output logic                      o_logic_rst,
   output logic                      o_loader_busy,
   output scr_pkg::scr_out_type      o_out_state
);
   import scr_pkg::*;

   typedef struct packed {
      logic       strap_taken;
      logic [6:0] strap;
      logic       override_sel;
      logic [6:0] addr_reg;
      logic [7:0] gencfg;
      logic       reload_req;
      logic       full_rst;
      logic [3:0] rst_cnt;
      logic [7:0] rdata;
      scr_out_type out_state;
   } scr_state_type;

   scr_state_type r;
   scr_state_type next_r;
   logic          ld_busy;
   logic          ld_done;
   logic          ld_cksum;
   logic [6:0]    addr_in_use;
   logic          in_full;

   // The full reset pulse also clears the registers, so treat it as reset
   assign in_full = i_sys_rst | r.full_rst;

   assign addr_in_use = r.override_sel ? r.addr_reg : r.strap;

   always_comb
   begin
      next_r = r;
      next_r.reload_req = 1'b0;
      next_r.full_rst   = 1'b0;
      // Strap caught once after reset release, never under reset
      if (!r.strap_taken)
      begin
         next_r.strap       = i_strap_addr;
         next_r.addr_reg    = i_strap_addr;
         next_r.strap_taken = 1'b1;
      end
      if (r.rst_cnt != 4'h0)
         next_r.rst_cnt = r.rst_cnt - 4'h1;
      // Writes
      if (i_req.wr)
      begin
         unique case (i_req.addr)
            REG_BUS_ADDRESS_SELECT:
            begin
               if (r.override_sel)
                  next_r.addr_reg = i_req.wdata[7:1];
               next_r.override_sel = i_req.wdata[BIT_OVERRIDE];
            end
            REG_SOFT_RESET_CONTROL:
            begin
               next_r.reload_req = i_req.wdata[BIT_RELOAD];
               next_r.full_rst = i_req.wdata[BIT_FULL_RST];
               if (i_req.wdata[BIT_LOGIC_RST])
                  next_r.rst_cnt = SOFT_RST_CYCLES;
            end
            REG_GENERAL_CONFIGURATION: next_r.gencfg = i_req.wdata & GENCFG_MASK;
            default: ;
         endcase
      end
      // Reads; self-clearing bits always read zero
      next_r.rdata = 8'h00;
      if (i_req.rd)
      begin
         unique case (i_req.addr)
            REG_BUS_ADDRESS_SELECT:    next_r.rdata = {addr_in_use, r.override_sel};
            REG_SOFT_RESET_CONTROL:    next_r.rdata = 8'h00;
            REG_GENERAL_CONFIGURATION: next_r.rdata = r.gencfg;
            REG_DEVICE_STATUS:
            begin
               next_r.rdata[BIT_INIT_DONE] = ld_done;
               next_r.rdata[BIT_CKSUM_OK]  = ld_cksum;
               next_r.rdata[BIT_REFCLK_OK] = i_refclk_detect;
            end
            default:                   next_r.rdata = 8'h00;
         endcase
      end
      // Output lane state
      if (!i_any_lock && !r.gencfg[BIT_OUT_MODE])
         next_r.out_state = SCR_OUT_HIZ;
      else if (r.gencfg[BIT_SLEEP_SEL] && !r.gencfg[BIT_OUT_EN])
         next_r.out_state = SCR_OUT_HIZ;
      else if (!i_any_lock && !r.gencfg[BIT_SLEEP_SEL])
         next_r.out_state = SCR_OUT_HS0;
      else if (!i_any_lock)
         next_r.out_state = SCR_OUT_LP11;
      else
         next_r.out_state = SCR_OUT_NORMAL;
   end

   // One register for all state; a full soft reset behaves like power-down
   always_ff @(posedge i_clk)
   begin
      if (in_full)
      begin
         r.strap_taken  <= 1'b0;
         r.strap        <= 7'h00;
         r.override_sel <= 1'b0;
         r.addr_reg     <= 7'h00;
         // controller off at reset, parity on
         r.gencfg       <= GENCFG_RESET;
         r.reload_req   <= 1'b0;
         r.full_rst     <= 1'b0;
         r.rst_cnt      <= SOFT_RST_CYCLES;
         r.rdata        <= 8'h00;
         r.out_state    <= SCR_OUT_HIZ;
      end
      else
         r <= next_r;
   end

   // Loader restarts on a reload request or a full reset; the logic-only reset leaves it alone
   scr_loader #(
      .ROM_WORDS (ROM_WORDS)
   ) u_loader (
      .i_clk      (i_clk),
      .i_sys_rst  (in_full),
      .i_start    (r.reload_req),
      .i_rom_ok   (i_rom_ok),
      .o_busy     (ld_busy),
      .o_done     (ld_done),
      .o_cksum_ok (ld_cksum)
   );

   assign o_rdata           = r.rdata;
   assign o_bus_address     = addr_in_use;
   assign o_cfg.ctrl_en     = r.gencfg[BIT_CTRL_EN];
   assign o_cfg.out_mode    = r.gencfg[BIT_OUT_MODE];
   assign o_cfg.out_en      = r.gencfg[BIT_OUT_EN];
   assign o_cfg.sleep_sel   = r.gencfg[BIT_SLEEP_SEL];
   assign o_cfg.parity_en   = r.gencfg[BIT_PARITY_EN];
   assign o_cfg.refclk_force = r.gencfg[BIT_REFCLK_FRC];
   assign o_refclk_present  = r.gencfg[BIT_REFCLK_FRC] | i_refclk_detect;
   assign o_logic_rst       = (r.rst_cnt != 4'h0);
   assign o_loader_busy     = ld_busy;
   assign o_out_state       = r.out_state;
endmodule // scr_regs
`default_nettype wire

/* bench/scr_regs_props.sv */
// Checker for the configuration and soft reset register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_props #(
   parameter int ROM_WORDS = 16
) (
   // Clock, reset and requests
   input wire logic                 i_clk,
   input wire logic                 i_sys_rst,
   input wire scr_pkg::scr_req_type i_req,
   input wire logic                 i_any_lock,
   input wire logic                 i_refclk_detect,
   // Observed outputs
   input wire logic [7:0]           o_rdata,
   input wire logic [6:0]           o_bus_address,
   input wire scr_pkg::scr_cfg_type o_cfg,
   input wire logic                 o_refclk_present,
   input wire logic                 o_logic_rst,
   input wire logic                 o_loader_busy,
   input wire scr_pkg::scr_out_type o_out_state
);
   import scr_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Decoded requests; output checks skip the internal reset where state is forced
   wire logic rd0 = i_req.rd && i_req.addr == 8'h00;
   wire logic wr1 = i_req.wr && i_req.addr == 8'h01;
   wire logic unl = !i_any_lock && !o_logic_rst;
   a_addr_readback: assert property (rd0 |=> o_rdata[7:1] == $past(o_bus_address))
      else $error("address field differs from address in use");
   a_cfg_readback: assert property (i_req.rd && i_req.addr == 8'h02 |=> o_rdata == {2'b00, $past(o_cfg)})
      else $error("configuration readback wrong");
   a_rstctl_zero: assert property (i_req.rd && i_req.addr == 8'h01 |=> o_rdata == 8'h00)
      else $error("reset control reads nonzero");
   a_cfg_defaults: assert property (disable iff (1'b0) i_sys_rst |=> o_cfg == GENCFG_RESET[5:0])
      else $error("configuration not at defaults after reset");
   a_full_reset: assert property (wr1 && i_req.wdata[1] |-> ##[1:3] o_cfg == GENCFG_RESET[5:0])
      else $error("full soft reset left configuration");
   a_logic_reset: assert property (wr1 && i_req.wdata[0] |-> ##[1:2] o_logic_rst)
      else $error("logic reset not launched");
   a_reload_start: assert property (wr1 && i_req.wdata[2] |-> ##[1:2] o_loader_busy)
      else $error("ROM reload not started");
   a_refclk_force: assert property (o_refclk_present == (o_cfg.refclk_force | i_refclk_detect))
      else $error("reference clock indication wrong");
   a_unlocked_hiz: assert property (unl && !o_cfg.out_mode ##1 unl && !o_cfg.out_mode |-> o_out_state == SCR_OUT_HIZ)
      else $error("unlocked port not high impedance");
   a_sleep_hiz: assert property (o_cfg.sleep_sel && !o_cfg.out_en ##1 o_cfg.sleep_sel && !o_cfg.out_en
      && !o_logic_rst |-> o_out_state == SCR_OUT_HIZ)
      else $error("disabled output not high impedance");
   a_sleep_hs0: assert property (unl && o_cfg.out_mode && !o_cfg.sleep_sel ##1 unl && o_cfg.out_mode
      && !o_cfg.sleep_sel |-> o_out_state == SCR_OUT_HS0)
      else $error("unlocked sleep state not HS-0");
   a_unlocked_lp11: assert property (unl && o_cfg == 6'h1E ##1 unl && o_cfg == 6'h1E |-> o_out_state == SCR_OUT_LP11)
      else $error("unlocked normal mode not LP-11");
   c_reload: cover property (wr1 && i_req.wdata[2]);
   c_full: cover property (wr1 && i_req.wdata[1]);
   c_hs0: cover property (o_out_state == SCR_OUT_HS0);
endmodule // scr_regs_props
bind scr_regs scr_regs_props #(.ROM_WORDS(ROM_WORDS)) u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
   .i_any_lock(i_any_lock), .i_refclk_detect(i_refclk_detect), .o_rdata(o_rdata), .o_bus_address(o_bus_address),
   .o_cfg(o_cfg), .o_refclk_present(o_refclk_present), .o_logic_rst(o_logic_rst), .o_loader_busy(o_loader_busy),
   .o_out_state(o_out_state));
`default_nettype wire

/* bench/scr_host.sv */
// Register host model issuing single-byte requests
`timescale 1ns/1ps
`default_nettype none
module scr_host (
   // Clock and read data
   input  wire logic                i_clk,
   input  wire logic [7:0]          i_rdata,
   // Request to the bank
   output var scr_pkg::scr_req_type o_req
);
   import scr_pkg::*;
   initial o_req = '0;
   // One strobe per call, held over the taking edge; leaves an idle cycle between calls
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge i_clk);
      o_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge i_clk);
      o_req = '0;
      q = i_rdata;
   endtask
endmodule // scr_host
`default_nettype wire

/* bench/scr_regs_tb.sv */
// Self-checking bench for the configuration and soft reset register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_tb;
   import scr_pkg::*;
   typedef struct packed { logic [7:0] wd; scr_out_type st; } scr_row_type;
   localparam scr_row_type ROWS [6] = '{'{8'hFF, SCR_OUT_LP11}, '{8'h00, SCR_OUT_HIZ}, '{8'h1A, SCR_OUT_HS0},
                                        '{8'h14, SCR_OUT_HIZ}, '{8'hC1, SCR_OUT_HIZ}, '{8'h1E, SCR_OUT_LP11}};
   logic        i_clk, i_sys_rst, i_rom_ok, i_refclk_detect, i_any_lock;
   logic        o_refclk_present, o_logic_rst, o_loader_busy;
   logic [6:0]  i_strap_addr, o_bus_address;
   logic [7:0]  o_rdata, q;
   scr_req_type i_req;
   scr_cfg_type o_cfg;
   scr_out_type o_out_state;
   int          n_errors = 0, checks = 0, cyc = 0;
   scr_regs #(.ROM_WORDS(4)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rdata(o_rdata),
      .i_strap_addr(i_strap_addr), .i_rom_ok(i_rom_ok), .i_refclk_detect(i_refclk_detect), .i_any_lock(i_any_lock),
      .o_bus_address(o_bus_address), .o_cfg(o_cfg), .o_refclk_present(o_refclk_present), .o_logic_rst(o_logic_rst),
      .o_loader_busy(o_loader_busy), .o_out_state(o_out_state));
   scr_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_req(i_req));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Hang guard, far above the fewer than a hundred cycles the sequence needs
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic wait_init();
      int k;
      q = 8'h00;
      for (k = 0; k < 60 && q[6] !== 1'b1; k++)
         rd(8'h04);
      chk("init_done", {7'h00, q[6]}, 8'h01);
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      i_sys_rst = 1'b1;
      i_strap_addr = 7'h2D;
      i_rom_ok = 1'b1;
      i_refclk_detect = 1'b0;
      i_any_lock = 1'b0;
      repeat (5) @(negedge i_clk);
      i_sys_rst = 1'b0;
      wait_init();
      // Defaults after power-down reset
      rd(8'h00); chk("addr", q, {7'h2D, 1'b0});
      rd(8'h02); chk("gencfg", q, 8'h1E);
      rd(8'h04); chk("status", q, 8'hC0);
      rd(8'h10); chk("unmapped", q, 8'h00);
      i_refclk_detect = 1'b1;
      @(negedge i_clk);
      chk("refclk", {7'h00, o_refclk_present}, 8'h01);
      i_refclk_detect = 1'b0;
      // Configuration rows with no receiver locked
      foreach (ROWS[i])
      begin
         wr(8'h02, ROWS[i].wd);
         rd(8'h02); chk("gencfg", q, ROWS[i].wd & 8'h3F);
         chk("cfg", {2'b00, o_cfg}, ROWS[i].wd & 8'h3F);
         chk("refclk", {7'h00, o_refclk_present}, {7'h00, ROWS[i].wd[0]});
         chk("state", {6'h00, o_out_state}, {6'h00, ROWS[i].st});
      end
      i_any_lock = 1'b1;
      repeat (2) @(negedge i_clk);
      chk("state", {6'h00, o_out_state}, {6'h00, SCR_OUT_NORMAL});
      i_any_lock = 1'b0;
      // Address field refused until the override is set first
      wr(8'h00, 8'hAA);
      rd(8'h00); chk("addr", q, {7'h2D, 1'b0});
      wr(8'h00, 8'h01);
      wr(8'h00, 8'hAB);
      rd(8'h00); chk("addr", q, 8'hAB);
      chk("bus_addr", {1'b0, o_bus_address}, 8'h55);
      wr(8'h01, 8'h01);
      chk("logic_rst", {7'h00, o_logic_rst}, 8'h01);
      rd(8'h01); chk("rstctl", q, 8'h00);
      rd(8'h00); chk("addr", q, 8'hAB);
      chk("logic_rst", {7'h00, o_logic_rst}, 8'h00);
      // ROM reload, then full reset back to straps
      wr(8'h01, 8'h04);
      // The request is registered once before the loader sees it
      @(negedge i_clk);
      chk("busy", {7'h00, o_loader_busy}, 8'h01);
      wait_init();
      rd(8'h01); chk("rstctl", q, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h02);
      wait_init();
      rd(8'h00); chk("addr", q, {7'h2D, 1'b0});
      rd(8'h02); chk("gencfg", q, 8'h1E);
      print_verdict();
   end
endmodule // scr_regs_tb
`default_nettype wire
